// ==== design/sfx_defs.vh ====
// Constants for the status flag instruction execution block
`ifndef SFX_DEFS_VH
`define SFX_DEFS_VH
// Status flag register bit positions
`define SFX_BIT_C 3'd0
`define SFX_BIT_Z 3'd1
`define SFX_BIT_N 3'd2
`define SFX_BIT_V 3'd3
`define SFX_BIT_S 3'd4
`define SFX_BIT_H 3'd5
`define SFX_BIT_T 3'd6
`define SFX_BIT_I 3'd7
`define SFX_FLAGS_RST 8'h00
// Opcode encoding: bit 3 set means flag op, bit 4 set means set else clear
`define SFX_OP_NOP 5'h00
`define SFX_OP_BREAK 5'h01
`define SFX_OP_SLEEP 5'h02
`define SFX_OP_WDR 5'h03
`define SFX_OP_MEM 5'h04
`define SFX_OP_FLAG_CLR 2'b01
`define SFX_OP_FLAG_SET 2'b11
// Extra cycle for on-chip SRAM data accesses
`define SFX_SRAM_EXTRA 1'h1
// Opcode field positions
`define SFX_OP_FLAG_BIT 3
`define SFX_OP_POL_BIT 4
`define SFX_OP_IDX_HI 2
`define SFX_OP_IDX_LO 0
// Number of status flags
`define SFX_NUM_FLAGS 8
// Counter value on the last cycle of a memory access
`define SFX_CNT_LAST 1'h1
// Listed count that marks an external interface access
`define SFX_EXT_BASE 1'h0
`endif

// ==== design/sfx_exec.v ====
// Status flag set/clear and control instruction execution stage
//
// Summary of operation
// [RL1] Set-overflow forces V to one in one cycle, other flags kept.
// [RL2] Clear-overflow forces V to zero in one cycle, other flags kept.
// [RL3] Set-half-carry forces H to one in one cycle, other flags kept.
// [RL4] Clear-half-carry forces H to zero in one cycle, other flags kept.
// [RL5] Set-sign-test forces S to one in one cycle, other flags kept.
// [RL6] Clear-sign-test forces S to zero in one cycle, other flags kept.
// [RL7] Listed memory cycle counts hold only for on-chip memory accesses.
// [RL8] On-chip SRAM data access costs one cycle beyond the listed count.
// [RL9] I, N, Z, T (and C) have single-cycle set and clear instructions.
// [RL10] NOP, break, sleep, watchdog reset take one cycle; NOP changes nothing.
`timescale 1ns/1ps
`include "sfx_defs.vh"

module sfx_exec #(
  parameter CNT_W = 4
) (
  input wire sys_clk,
  input wire nrst,
  input wire instr_valid,
  input wire [4:0] instr_op,
  input wire [CNT_W-1:0] mem_base_cycles,
  input wire mem_sram,
  input wire mem_ext_done,
  output wire instr_ready,
  output reg [7:0] status_flag_register,
  output reg break_pulse,
  output reg sleep_pulse,
  output reg wdr_pulse,
  output reg done_pulse
);

  // ***************************************
  // Local constants and state encoding
  // ***************************************
  localparam NUM_FLAGS = `SFX_NUM_FLAGS;
  localparam [7:0] FLAGS_RST = `SFX_FLAGS_RST;
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, `SFX_CNT_LAST};
  localparam [CNT_W-1:0] SRAM_ADD = {{(CNT_W-1){1'b0}}, `SFX_SRAM_EXTRA};
  localparam [CNT_W-1:0] EXT_BASE = {{(CNT_W-1){1'b0}}, `SFX_EXT_BASE};

  // Idle takes work, MEM counts listed plus SRAM extra cycles, EXT waits for the interface
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_MEM = 2'b01;
  localparam [1:0] ST_EXT = 2'b10;

  // ***************************************
  // Declarations
  // ***************************************
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  reg done_d;
  reg break_d;
  reg sleep_d;
  reg wdr_d;
  wire idle;
  wire take;
  wire is_flag;
  wire is_mem;
  wire is_ctrl;
  wire flag_value;
  wire [2:0] flag_idx;
  wire mem_is_ext;
  wire [CNT_W-1:0] sram_add;
  wire [CNT_W-1:0] mem_total;
  wire mem_single;
  wire cnt_last;
  wire [7:0] flags_d;

  // ***************************************
  // Instruction decode
  // ***************************************
  assign idle = (state_q == ST_IDLE);
  assign instr_ready = idle;
  assign take = instr_valid & idle;
  assign is_flag = instr_op[`SFX_OP_FLAG_BIT];
  assign flag_value = instr_op[`SFX_OP_POL_BIT];
  assign flag_idx = instr_op[`SFX_OP_IDX_HI:`SFX_OP_IDX_LO];
  assign is_mem = (instr_op == `SFX_OP_MEM);
  // Neither a flag op nor a memory access: a control op
  assign is_ctrl = ~is_flag & ~is_mem;

  // ***************************************
  // Memory access cycle count
  // ***************************************
  // A listed count of zero off the SRAM marks an external interface access
  assign mem_is_ext = ~mem_sram & (mem_base_cycles == EXT_BASE); // RL7
  assign sram_add = mem_sram ? SRAM_ADD : CNT_ZERO; // RL8
  // Wraps if an SRAM access's listed count already sits at the counter's ceiling
  assign mem_total = mem_base_cycles + sram_add; // RL8
  assign mem_single = ~mem_is_ext & (mem_total <= CNT_ONE);
  assign cnt_last = (cnt_q <= CNT_ONE);

  // ***************************************
  // Status flag update
  // ***************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi = gi + 1)
    begin : g_flag
      localparam [2:0] IDX = gi;
      wire hit;
      // Only the addressed flag may change; all others keep their value
      assign hit = take & is_flag & (flag_idx == IDX); // RL1 RL2 RL3 RL4 RL5 RL6 RL9
      assign flags_d[gi] = hit ? flag_value : status_flag_register[gi]; // RL9
    end
  endgenerate

  // ***************************************
  // Sequencing
  // ***************************************
  // Done is raised on the edge that ends the instruction, so a one-cycle
  // instruction shows it right after the edge that took it
  always @*
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (take)
        begin
          if (is_mem)
          begin
            if (mem_single)
              done_d = 1'b1;
            else if (mem_is_ext)
              state_d = ST_EXT; // RL7
            else
            begin
              state_d = ST_MEM; // RL8
              cnt_d = mem_total - CNT_ONE;
            end
          end
          else
            done_d = 1'b1; // RL9 RL10
        end
      end
      ST_MEM:
      begin
        cnt_d = cnt_q - CNT_ONE;
        if (cnt_last)
        begin
          state_d = ST_IDLE;
          done_d = 1'b1; // RL8
        end
      end
      ST_EXT:
      begin
        // External accesses end on the interface's own done, not a count
        if (mem_ext_done)
        begin
          state_d = ST_IDLE;
          done_d = 1'b1; // RL7
        end
      end
      default:
      begin
        state_d = ST_IDLE;
        cnt_d = CNT_ZERO;
      end
    endcase
  end

  // ***************************************
  // Control instructions
  // ***************************************
  // NOP and unused codes raise nothing but done
  always @*
  begin
    break_d = 1'b0;
    sleep_d = 1'b0;
    wdr_d = 1'b0;
    if (take & is_ctrl)
    begin
      case (instr_op)
        `SFX_OP_BREAK: break_d = 1'b1; // RL10
        `SFX_OP_SLEEP: sleep_d = 1'b1; // RL10
        `SFX_OP_WDR: wdr_d = 1'b1; // RL10
        default: break_d = 1'b0; // RL10
      endcase
    end
  end

  // ***************************************
  // Sequencer registers
  // ***************************************
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ***************************************
  // Output registers
  // ***************************************
  // Flags and pulses come straight from flip-flops so they never glitch
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      status_flag_register <= FLAGS_RST;
      break_pulse <= 1'b0;
      sleep_pulse <= 1'b0;
      wdr_pulse <= 1'b0;
      done_pulse <= 1'b0;
    end
    else
    begin
      status_flag_register <= flags_d;
      break_pulse <= break_d;
      sleep_pulse <= sleep_d;
      wdr_pulse <= wdr_d;
      done_pulse <= done_d;
    end
  end

endmodule // sfx_exec

// ==== testbench/sfx_exec_properties.sv ====
// Flag execution assertions
`timescale 1ns/1ps
module sfx_exec_chk (
  input wire sys_clk,
  input wire nrst,
  input wire instr_valid,
  input wire instr_ready,
  input wire done_pulse,
  input wire [4:0] instr_op,
  input wire [7:0] status_flag_register
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire [5:0] t = {instr_valid & instr_ready, instr_op};
  wire [7:0] f = status_flag_register;
  v_set_a: assert property (t == 6'h3B |=> f[3]) else $error("V set");
  v_clr_a: assert property (t == 6'h2B |=> !f[3]) else $error("V clear");
  h_set_a: assert property (t == 6'h3D |=> f[5]) else $error("H set");
  h_clr_a: assert property (t == 6'h2D |=> !f[5]) else $error("H clear");
  s_set_a: assert property (t == 6'h3C |=> f[4]) else $error("S set");
  s_clr_a: assert property (t == 6'h2C |=> !f[4]) else $error("S clear");
  flag_only_a: assert property (t[5] && instr_op[3] |=>
    ((f ^ $past(f)) & ~(8'h01 << $past(instr_op[2:0]))) == 8'h00)
    else $error("Other flag moved");
  flag_hold_a: assert property (!t[5] |=> $stable(f)) else $error("Flags moved");
  nop_done_a: assert property (t == 6'h20 |=> $stable(f) && done_pulse) else $error("NOP");
endmodule // sfx_exec_chk
bind sfx_exec sfx_exec_chk sfx_exec_chk_inst (.*);

// ==== testbench/sfx_exec_tb_top.sv ====
// Flag execution bench
`timescale 1ns/1ps
module sfx_exec_tb_top;
  reg sys_clk = 1'h0, nrst = 1'h0, v = 1'h0, s = 1'h0, x = 1'h0;
  reg [4:0] o = 5'h00;
  reg [3:0] b = 4'h0;
  reg [7:0] e = 8'h00;
  wire r, d, bp, sp, wp;
  wire [7:0] f;
  integer errors = 0, checks = 0, n = 0, i;
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    n++;
    if (n == 200)
    begin
      errors++;
      summarize;
    end
  end
  sfx_exec sfx_exec_inst (.sys_clk, .nrst, .instr_valid(v), .instr_op(o), .mem_base_cycles(b),
    .mem_sram(s), .mem_ext_done(x), .instr_ready(r), .status_flag_register(f),
    .break_pulse(bp), .sleep_pulse(sp), .wdr_pulse(wp), .done_pulse(d));
  task chk(input [7:0] a, x);
    checks++;
    errors += a !== x;
    if (a !== x) $display("Error %0t %h %h", $time, a, x);
  endtask
  task flag_seq;
    for (i = 0; i < 16; i++)
    begin
      v = 1'h1;
      o = {~i[3], 1'h1, i[2:0]};
      e[i[2:0]] = ~i[3];
      @(posedge sys_clk) #1;
      chk(f, e);
      chk({7'h00, d}, 8'h01);
    end
    v = 1'h0;
    @(posedge sys_clk) #1;
    chk({7'h00, d}, 8'h00);
  endtask
  task ctrl_seq;
    for (i = 0; i < 4; i++)
    begin
      v = 1'h1;
      o = i[4:0];
      @(posedge sys_clk) #1;
      chk({4'h0, bp, sp, wp, d}, {4'h0, i == 1, i == 2, i == 3, 1'h1});
      chk(f, e);
    end
    v = 1'h0;
    @(posedge sys_clk) #1;
    chk({4'h0, bp, sp, wp, d}, 8'h00);
  endtask
  task mem_seq;
    {v, o, b, s} = {1'h1, 5'h04, 4'h2, 1'h1};
    @(posedge sys_clk) #1;
    v = 1'h0;
    chk({6'h00, r, d}, 8'h00);
    @(posedge sys_clk) #1;
    chk({6'h00, r, d}, 8'h00);
    @(posedge sys_clk) #1;
    chk({6'h00, r, d}, 8'h03);
    @(posedge sys_clk) #1;
    chk({6'h00, r, d}, 8'h02);
    {v, o, b, s} = {1'h1, 5'h04, 4'h2, 1'h0};
    @(posedge sys_clk) #1;
    v = 1'h0;
    chk({6'h00, r, d}, 8'h00);
    @(posedge sys_clk) #1;
    chk({6'h00, r, d}, 8'h03);
  endtask
  task ext_seq;
    {v, o, b, s} = {1'h1, 5'h04, 4'h0, 1'h0};
    @(posedge sys_clk) #1;
    v = 1'h0;
    repeat (3) @(posedge sys_clk) #1;
    chk({6'h00, r, d}, 8'h00);
    x = 1'h1;
    @(posedge sys_clk) #1;
    x = 1'h0;
    chk({6'h00, r, d}, 8'h03);
    chk(f, e);
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    #1 nrst = 1'h1;
    flag_seq;
    ctrl_seq;
    mem_seq;
    ext_seq;
    summarize;
  end
  task summarize;
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
endmodule // sfx_exec_tb_top
